// >>> verilog/dewc_regs.vh
// Register selectors, field positions, reset values and timing counts
// for the nonvolatile data array write control block.
// Assumes inclusion by bare name from the design files.
`ifndef DEWC_REGS_VH
`define DEWC_REGS_VH

// Register select codes on the special function register port
`define DEWC_SEL_ADDR_LOW 3'h0
`define DEWC_SEL_ADDR_HIGH 3'h1
`define DEWC_SEL_DATA 3'h2
`define DEWC_SEL_UNLOCK 3'h3
`define DEWC_SEL_CONTROL 3'h4
`define DEWC_SEL_DONE 3'h5

// Control register field positions
`define DEWC_CTL_PROG_SEL 7
`define DEWC_CTL_CFG_SEL 6
`define DEWC_CTL_ERASE_EN 4
`define DEWC_CTL_ABORT 3
`define DEWC_CTL_PERMIT 2
`define DEWC_CTL_LAUNCH 1
`define DEWC_CTL_READ 0

// Done flag position in its status register
`define DEWC_DONE_FLAG 0

// Unlock key values
`define DEWC_KEY_FIRST 8'h55
`define DEWC_KEY_SECOND 8'hAA

// Address layout: low byte plus two high bits
`define DEWC_ADDR_HIGH_MASK 8'h03

// Reset values
`define DEWC_RST_BYTE 8'h00

// Timing: self-timed write duration and power-up hold, in microseconds
`define DEWC_CLK_MHZ 125
`define DEWC_WRITE_TIME_US 4000
`define DEWC_HOLD_TIME_US 65600
`define DEWC_WRITE_CYCLES (`DEWC_WRITE_TIME_US * `DEWC_CLK_MHZ)
`define DEWC_HOLD_CYCLES (`DEWC_HOLD_TIME_US * `DEWC_CLK_MHZ)

`endif

// >>> verilog/dewc_unlock.v
// Unlock sequence tracker for the write launch.
// Assumes one register write at most per clock, presented as a strobe.
`timescale 1ns/1ps
`include "dewc_regs.vh"

module dewc_unlock
(
    input wire clk_i,          // System clock
    input wire rst_n_i,        // Asynchronous reset, active low
    input wire wr_i,           // Register write strobe
    input wire [2:0] sel_i,    // Register select
    input wire [7:0] wdata_i,  // Write data
    output wire armed_o        // Both keys seen, next write may launch
);

    localparam ST_IDLE = 2'h0; // No key seen
    localparam ST_ONE = 2'h1;  // First key seen
    localparam ST_TWO = 2'h2;  // Second key seen, armed

    reg [1:0] state_r;  // Tracker state
    reg [1:0] state_nxt; // Next tracker state

    assign armed_o = (state_r == ST_TWO);

    // Any write breaks the chain unless it is the exact next key
    always @*
    begin
        state_nxt = state_r;
        if (wr_i)
        begin
            case (state_r)
                ST_IDLE:
                    if (sel_i == `DEWC_SEL_UNLOCK && wdata_i == `DEWC_KEY_FIRST)
                        state_nxt = ST_ONE;
                ST_ONE:
                    if (sel_i == `DEWC_SEL_UNLOCK && wdata_i == `DEWC_KEY_SECOND)
                        state_nxt = ST_TWO;
                    else
                        state_nxt = ST_IDLE;
                default:
                    state_nxt = ST_IDLE; // Launch write or anything else consumes it
            endcase
        end
    end

    // State register
    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            state_r <= ST_IDLE;
        else
            state_r <= state_nxt;
    end

endmodule

// >>> verilog/dewc_timer.v
// Down counter used for the self-timed write and the power-up hold.
// Assumes start is a one-cycle pulse; a load while busy restarts it.
`timescale 1ns/1ps

module dewc_timer
#(
    parameter W = 24,              // Counter width
    parameter [W-1:0] COUNT = 1,   // Cycles from start to done
    parameter START_AT_RESET = 0   // Run from reset release when set
)
(
    input wire clk_i,    // System clock
    input wire rst_n_i,  // Asynchronous reset, active low
    input wire start_i,  // Start pulse
    output wire busy_o,  // Counting
    output wire done_o   // One-cycle pulse at expiry
);

    reg [W-1:0] cnt_r; // Remaining cycles, zero when idle

    assign busy_o = (cnt_r != {W{1'b0}});
    assign done_o = (cnt_r == {{(W-1){1'b0}}, 1'b1});

    // Load on start, count down to zero otherwise
    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            cnt_r <= (START_AT_RESET != 0) ? COUNT : {W{1'b0}};
        else if (start_i)
            cnt_r <= COUNT;
        else if (busy_o)
            cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
    end

endmodule

// >>> verilog/dewc_top.v
// Write control for the byte-addressed nonvolatile data array, reached
// through special function registers of the on-chip processor.
// Assumes a single-cycle register port synchronous to clk_i and an array
// macro that accepts a one-cycle write pulse and reads combinationally.
`timescale 1ns/1ps
`include "dewc_regs.vh"

module dewc_top
#(
    parameter AW = 10,                                 // Array address width
    parameter [31:0] WRITE_CYCLES = `DEWC_WRITE_CYCLES, // Self-timed write length
    parameter [31:0] HOLD_CYCLES = `DEWC_HOLD_CYCLES    // Power-up hold length
)
(
    input wire clk_i,             // System clock, 125 MHz
    input wire rst_n_i,           // Asynchronous reset, active low
    input wire por_n_i,           // Power-on reset marker, low on power-up
    input wire sfr_wr_i,          // Register write strobe
    input wire sfr_rd_i,          // Register read strobe
    input wire [2:0] sfr_sel_i,   // Register select
    input wire [7:0] sfr_wdata_i, // Register write data
    output reg [7:0] sfr_rdata_o, // Register read data, registered
    output reg nv_done_flag_o,    // Write done flag
    input wire code_protect_i,    // Array code-protect configuration bit
    input wire ext_req_i,         // External programmer access request
    input wire ext_we_i,          // External programmer write
    input wire [AW-1:0] ext_addr_i, // External programmer address
    input wire [7:0] ext_wdata_i, // External programmer data
    output reg [7:0] ext_rdata_o, // External programmer read data
    output reg ext_denied_o,      // External access refused pulse
    output reg arr_we_o,          // Array write pulse
    output reg [AW-1:0] arr_addr_o, // Array write address
    output reg [7:0] arr_wdata_o, // Array write data
    input wire [7:0] arr_rdata_i, // Array read data at arr_raddr
    output reg [AW-1:0] arr_raddr_o // Array read address, registered
);

    reg [7:0] addr_low_r;    // Address bits 7..0
    reg [1:0] addr_high_r;   // Address bits 9..8
    reg [7:0] data_r;        // Data byte
    reg prog_sel_r;          // Program memory select
    reg cfg_sel_r;           // Configuration select
    reg erase_en_r;          // Row erase enable, kept for software
    reg abort_r;             // Aborted-write flag
    reg permit_r;            // Program permit bit
    reg launch_r;            // Program launch bit, set while writing
    reg read_r;              // Read launch bit
    reg wr_flight_r;         // Write running, mirrors the timer
    reg ext_rd_pend_r;       // External read waiting for data
    wire armed;              // Unlock keys both seen
    wire wtmr_busy;          // Write timer running
    wire wtmr_done;          // Write timer expiry pulse
    wire hold_busy;          // Power-up hold running
    wire wr_ctl;             // Software write of control
    wire launch_req;         // Launch attempt this cycle
    wire launch_ok;          // Launch accepted this cycle
    wire locked;             // Registers locked by a running write
    wire [AW-1:0] cpu_addr;  // Processor address
    wire ext_ok;             // External access allowed
    wire rd_start;           // Processor data read accepted this cycle

    // Count one full write time; the hold counter runs from power-up
    dewc_timer #(.W(32), .COUNT(WRITE_CYCLES), .START_AT_RESET(0)) u_wtmr
    (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .start_i(launch_ok),
        .busy_o(wtmr_busy),
        .done_o(wtmr_done)
    );

    // Hold restarts only on power-on; an ordinary reset leaves it alone
    dewc_timer #(.W(32), .COUNT(HOLD_CYCLES), .START_AT_RESET(1)) u_hold
    (
        .clk_i(clk_i),
        .rst_n_i(por_n_i),
        .start_i(1'b0),
        .busy_o(hold_busy),
        .done_o()
    );

    // Key tracker; any stray register write breaks the chain
    dewc_unlock u_unlock
    (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .wr_i(sfr_wr_i),
        .sel_i(sfr_sel_i),
        .wdata_i(sfr_wdata_i),
        .armed_o(armed)
    );

    assign cpu_addr = {addr_high_r, addr_low_r};
    assign locked = launch_r;
    assign wr_ctl = sfr_wr_i && (sfr_sel_i == `DEWC_SEL_CONTROL);
    // A launch request while a write runs is neither taken nor flagged
    assign launch_req = wr_ctl && sfr_wdata_i[`DEWC_CTL_LAUNCH] && !launch_r;
    // Permit must already be set; the same write setting it does not count
    assign launch_ok = launch_req && permit_r && armed && !hold_busy;
    // External path only when protection is off and no write is running
    assign ext_ok = !code_protect_i && !launch_r;
    // Data reads only; the processor path ignores code protect entirely
    assign rd_start = wr_ctl && !locked && sfr_wdata_i[`DEWC_CTL_READ] &&
                      !sfr_wdata_i[`DEWC_CTL_PROG_SEL] &&
                      !sfr_wdata_i[`DEWC_CTL_CFG_SEL];

    // Power-up only: permit bit, done flag and abort flag; survive ordinary resets
    always @(posedge clk_i or negedge por_n_i)
    begin
        if (!por_n_i)
        begin
            permit_r <= 1'b0;
            nv_done_flag_o <= 1'b0;
            abort_r <= 1'b0;
        end
        else
        begin
            // Only software writes change permit; completion leaves it
            if (wr_ctl && !locked)
                permit_r <= sfr_wdata_i[`DEWC_CTL_PERMIT];
            // Set wins over a clear in the same cycle
            if (wtmr_done)
                nv_done_flag_o <= 1'b1;
            else if (sfr_wr_i && sfr_sel_i == `DEWC_SEL_DONE &&
                     !sfr_wdata_i[`DEWC_DONE_FLAG])
                nv_done_flag_o <= 1'b0;
            // Reset during a write, or a launch refused for missing permit, keys or the power-up hold
            if (!rst_n_i && wr_flight_r)
                abort_r <= 1'b1;
            else if (launch_req && !launch_ok)
                abort_r <= 1'b1;
            else if (wtmr_done)
                abort_r <= 1'b0;
            else if (wr_ctl && !locked && !sfr_wdata_i[`DEWC_CTL_ABORT])
                abort_r <= 1'b0;
        end
    end

    // Kept in the power-on domain so it still reads high at the first edge of an
    // ordinary reset; that is how a write cut short is noticed
    // Write in flight marker, seen by the abort detector above
    always @(posedge clk_i or negedge por_n_i)
    begin
        if (!por_n_i)
            wr_flight_r <= 1'b0;
        else
            wr_flight_r <= rst_n_i && (wtmr_busy || launch_ok);
    end

    // Address, data and control registers
    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            addr_low_r <= `DEWC_RST_BYTE;
            addr_high_r <= 2'h0;
            data_r <= `DEWC_RST_BYTE;
            prog_sel_r <= 1'b0;
            cfg_sel_r <= 1'b0;
            erase_en_r <= 1'b0;
            launch_r <= 1'b0;
            read_r <= 1'b0;
        end
        else
        begin
            read_r <= 1'b0;
            if (wtmr_done)
                launch_r <= 1'b0;
            else if (launch_ok)
                launch_r <= 1'b1;
            if (sfr_wr_i && !locked)
            begin
                // Writes while a write runs are dropped
                case (sfr_sel_i)
                    `DEWC_SEL_ADDR_LOW:
                        addr_low_r <= sfr_wdata_i;
                    `DEWC_SEL_ADDR_HIGH:
                        addr_high_r <= sfr_wdata_i[1:0];
                    `DEWC_SEL_DATA:
                        data_r <= sfr_wdata_i;
                    `DEWC_SEL_CONTROL:
                    begin
                        prog_sel_r <= sfr_wdata_i[`DEWC_CTL_PROG_SEL];
                        cfg_sel_r <= sfr_wdata_i[`DEWC_CTL_CFG_SEL];
                        erase_en_r <= sfr_wdata_i[`DEWC_CTL_ERASE_EN];
                        // One-cycle fetch into the data byte
                        if (rd_start)
                            read_r <= 1'b1;
                    end
                    default:
                        data_r <= data_r;
                endcase
            end
            if (read_r && !ext_rd_pend_r)
                data_r <= arr_rdata_i;
        end
    end

    // Array write port: processor launch or allowed external write
    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            arr_we_o <= 1'b0;
            arr_addr_o <= {AW{1'b0}};
            arr_wdata_o <= 8'h00;
            ext_rd_pend_r <= 1'b0;
            ext_rdata_o <= 8'h00;
            ext_denied_o <= 1'b0;
            arr_raddr_o <= {AW{1'b0}};
        end
        else
        begin
            arr_we_o <= 1'b0;
            ext_denied_o <= 1'b0;
            ext_rd_pend_r <= 1'b0;
            // Commit the byte when the self-timed write completes
            if (wtmr_done && !hold_busy)
            begin
                arr_we_o <= 1'b1;
                arr_addr_o <= cpu_addr;
                arr_wdata_o <= data_r;
            end
            else if (ext_req_i && ext_ok && ext_we_i && !hold_busy && !read_r)
            begin
                arr_we_o <= 1'b1;
                arr_addr_o <= ext_addr_i;
                arr_wdata_o <= ext_wdata_i;
            end
            // Refusal is reported even when a commit takes the write port
            if (ext_req_i && !ext_ok)
                ext_denied_o <= 1'b1;
            // Registered read address keeps the array input free of glitches;
            // a processor fetch claims the port, an external read in that cycle is dropped
            if (rd_start)
                arr_raddr_o <= cpu_addr;
            else if (ext_req_i && ext_ok && !ext_we_i)
            begin
                ext_rd_pend_r <= 1'b1;
                arr_raddr_o <= ext_addr_i;
            end
            else
                arr_raddr_o <= cpu_addr;
            if (ext_rd_pend_r)
                ext_rdata_o <= arr_rdata_i;
        end
    end

    // Reads have no side effects; the key register has no storage behind it
    // Read data, registered one cycle after the read strobe
    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            sfr_rdata_o <= 8'h00;
        else if (sfr_rd_i)
        begin
            case (sfr_sel_i)
                `DEWC_SEL_ADDR_LOW:
                    sfr_rdata_o <= addr_low_r;
                `DEWC_SEL_ADDR_HIGH:
                    sfr_rdata_o <= {6'h00, addr_high_r} & `DEWC_ADDR_HIGH_MASK;
                `DEWC_SEL_DATA:
                    sfr_rdata_o <= data_r;
                `DEWC_SEL_UNLOCK:
                    sfr_rdata_o <= 8'h00;
                `DEWC_SEL_CONTROL:
                    sfr_rdata_o <= {prog_sel_r, cfg_sel_r, 1'b0, erase_en_r,
                                    abort_r, permit_r, launch_r, read_r};
                `DEWC_SEL_DONE:
                    sfr_rdata_o <= {7'h00, nv_done_flag_o};
                default:
                    sfr_rdata_o <= 8'h00;
            endcase
        end
    end

endmodule

// >>> dv/dewc_chk.sv
// Port-level checker for the nonvolatile data array write control block.
// Assumes it is bound to dewc_top and sees only that module's ports.
`timescale 1ns/1ps

module dewc_chk
#(
    parameter [31:0] HOLD_CYCLES = 30 // Power-up hold length
)
(
    input logic clk_i,             // System clock
    input logic rst_n_i,           // Reset, active low
    input logic por_n_i,           // Power-on reset, active low
    input logic sfr_wr_i,          // Register write strobe
    input logic sfr_rd_i,          // Register read strobe
    input logic [2:0] sfr_sel_i,   // Register select
    input logic [7:0] sfr_wdata_i, // Register write data
    input logic [7:0] sfr_rdata_o, // Register read data
    input logic nv_done_flag_o,    // Write done flag
    input logic code_protect_i,    // Code-protect setting
    input logic ext_req_i,         // External request
    input logic ext_denied_o,      // External refusal pulse
    input logic arr_we_o           // Array write pulse
);
    logic [31:0] hold_cnt_r; // Cycles since power-on release, saturating

    // Counts from power-on only, so a plain reset never restarts the hold
    always @(posedge clk_i or negedge por_n_i)
    begin
        if (!por_n_i)
            hold_cnt_r <= 32'h0;
        else if (hold_cnt_r != 32'hFFFFFFFF)
            hold_cnt_r <= hold_cnt_r + 32'h1;
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i || !por_n_i);

    AST_KEY_ZERO: assert property (sfr_rd_i && sfr_sel_i == 3'h3 |=> sfr_rdata_o == 8'h00)
        else $error("unlock key read back non-zero");
    AST_HIGH_ZERO: assert property (sfr_rd_i && sfr_sel_i == 3'h1 |=> sfr_rdata_o[7:2] == 6'h0)
        else $error("upper address bits read non-zero");
    AST_CTL_B5: assert property (sfr_rd_i && sfr_sel_i == 3'h4 |=> !sfr_rdata_o[5])
        else $error("control bit 5 read non-zero");
    AST_DONE_SRC: assert property ($rose(nv_done_flag_o) |-> arr_we_o)
        else $error("done flag rose without array write");
    AST_DONE_HOLD: assert property (nv_done_flag_o && !(sfr_wr_i && sfr_sel_i == 3'h5) |=> nv_done_flag_o)
        else $error("done flag dropped by itself");
    AST_DONE_CLR: assert property (sfr_wr_i && sfr_sel_i == 3'h5 && !sfr_wdata_i[0]
        |=> !nv_done_flag_o || arr_we_o)
        else $error("done flag not cleared by software");
    AST_WE_PULSE: assert property (arr_we_o |=> !arr_we_o)
        else $error("array write pulse longer than one cycle");
    AST_HOLD: assert property (arr_we_o |-> hold_cnt_r >= HOLD_CYCLES)
        else $error("array written during power-up hold");
    AST_DENY: assert property (ext_req_i && code_protect_i |=> ext_denied_o)
        else $error("protected external access not refused");
    AST_ALLOW: assert property (ext_req_i && !code_protect_i |=> !ext_denied_o)
        else $error("unprotected external access refused");

    COV_WRITE: cover property (arr_we_o && nv_done_flag_o);
    COV_DENY: cover property (ext_denied_o);
    COV_CLEAR: cover property ($fell(nv_done_flag_o));
endmodule

// >>> dv/dewc_top_tb.sv
// Self-checking bench for the data array write control block.
// Drives register and external ports itself and models the array.
`timescale 1ns/1ps

module dewc_top_tb;
    localparam int WC = 20; // Shortened self-timed write
    localparam int HC = 30; // Shortened power-up hold
    // Refusal table: permit preset, two keys, launch value, control read
    localparam logic [7:0] PRE [6] = '{8'h04, 8'h00, 8'h00, 8'h04, 8'h04, 8'h04};
    localparam logic [7:0] KA [6] = '{8'h55, 8'h55, 8'h55, 8'hAA, 8'h55, 8'h55};
    localparam logic [7:0] KB [6] = '{8'hAA, 8'hAA, 8'hAA, 8'h55, 8'hA5, 8'hAA};
    localparam logic [7:0] LV [6] = '{8'h06, 8'h06, 8'h02, 8'h06, 8'h06, 8'h06};
    localparam logic [7:0] EX [6] = '{8'h0C, 8'h0C, 8'h08, 8'h0C, 8'h0C, 8'h0C};
    logic clk_i = 0, rst_n_i = 0, por_n_i = 0, sfr_wr_i = 0, sfr_rd_i = 0;
    logic code_protect_i = 0, ext_req_i = 0, ext_we_i = 0;
    logic [2:0] sfr_sel_i = 0;
    logic [7:0] sfr_wdata_i = 0, ext_wdata_i = 0;
    logic [9:0] ext_addr_i = 0;
    wire [7:0] sfr_rdata_o, ext_rdata_o, arr_wdata_o, arr_rdata_i;
    wire [9:0] arr_addr_o, arr_raddr_o;
    wire nv_done_flag_o, ext_denied_o, arr_we_o;
    logic [7:0] mem [0:1023];   // Array contents
    logic [7:0] model [0:1023]; // Expected contents
    int n_mismatch = 0, cmp_count = 0, we_cnt = 0;

    dewc_top #(.WRITE_CYCLES(WC), .HOLD_CYCLES(HC)) dewc_top_i (.clk_i(clk_i),
        .rst_n_i(rst_n_i), .por_n_i(por_n_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i),
        .sfr_sel_i(sfr_sel_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o),
        .nv_done_flag_o(nv_done_flag_o), .code_protect_i(code_protect_i),
        .ext_req_i(ext_req_i), .ext_we_i(ext_we_i), .ext_addr_i(ext_addr_i),
        .ext_wdata_i(ext_wdata_i), .ext_rdata_o(ext_rdata_o), .ext_denied_o(ext_denied_o),
        .arr_we_o(arr_we_o), .arr_addr_o(arr_addr_o), .arr_wdata_o(arr_wdata_o),
        .arr_rdata_i(arr_rdata_i), .arr_raddr_o(arr_raddr_o));

    // Array: combinational read, one write per pulse
    assign arr_rdata_i = mem[arr_raddr_o];
    always @(posedge clk_i)
    begin
        if (arr_we_o === 1'b1)
        begin
            mem[arr_addr_o] <= arr_wdata_o;
            we_cnt <= we_cnt + 1;
        end
    end

    initial
    begin
        forever #4 clk_i = ~clk_i;
    end

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Register write; strobe stays up so writes run back to back
    task automatic wr(input logic [2:0] s, input logic [7:0] d);
        sfr_wr_i <= 1'b1;
        sfr_sel_i <= s;
        sfr_wdata_i <= d;
        @(posedge clk_i);
    endtask

    task automatic idle(input int n);
        sfr_wr_i <= 1'b0;
        repeat (n) @(posedge clk_i);
    endtask

    // Register read; data is registered, so look one edge later
    task automatic rd(input logic [2:0] s, input logic [7:0] e);
        sfr_wr_i <= 1'b0;
        sfr_rd_i <= 1'b1;
        sfr_sel_i <= s;
        @(posedge clk_i);
        sfr_rd_i <= 1'b0;
        @(negedge clk_i);
        chk(sfr_rdata_o, e);
        @(posedge clk_i);
    endtask

    // External access; refusal one edge later, read data two edges later
    task automatic ext(input logic p, input logic w, input logic [9:0] a, input logic [7:0] d);
        code_protect_i <= p;
        ext_req_i <= 1'b1;
        ext_we_i <= w;
        ext_addr_i <= a;
        ext_wdata_i <= d;
        @(posedge clk_i);
        ext_req_i <= 1'b0;
        @(negedge clk_i);
        chk(ext_denied_o, p);
        @(negedge clk_i);
        if (!p && !w)
            chk(ext_rdata_o, model[a]);
        if (!p && w)
            model[a] = d;
        repeat (3) @(posedge clk_i);
    endtask

    // One byte write with locked-register pokes; cut resets it midway
    task automatic put(input logic [9:0] a, input logic [7:0] d, input logic cut);
        int k;
        int n0;
        n0 = we_cnt;
        wr(3'h0, a[7:0]);
        wr(3'h1, {6'h3F, a[9:8]});
        wr(3'h2, d);
        wr(3'h4, 8'h04);
        wr(3'h3, 8'h55);
        wr(3'h3, 8'hAA);
        wr(3'h4, 8'h06);
        wr(3'h0, ~a[7:0]);
        wr(3'h2, ~d);
        wr(3'h4, 8'h00);
        sfr_wr_i <= 1'b0;
        if (cut)
        begin
            rst_n_i <= 1'b0;
            idle(2);
            rst_n_i <= 1'b1;
            idle(WC);
            rd(3'h4, 8'h0C);
            chk(16'(we_cnt), 16'(n0));
            return;
        end
        k = 3;
        @(negedge clk_i);
        while (arr_we_o !== 1'b1 && k < WC + 9)
        begin
            @(negedge clk_i);
            k++;
        end
        if (arr_we_o !== 1'b1)
        begin
            chk(16'h0000, 16'h0001);
            return;
        end
        chk(16'(k), 16'(WC));
        chk({arr_addr_o, 6'h0}, {a, 6'h0});
        chk(arr_wdata_o, d);
        chk(nv_done_flag_o, 1'b1);
        model[a] = d;
        @(posedge clk_i);
        rd(3'h4, 8'h04);
        rd(3'h5, 8'h01);
        wr(3'h5, 8'h00);
        rd(3'h5, 8'h00);
        wr(3'h4, 8'h05);
        idle(1);
        rd(3'h2, model[a]);
        rd(3'h4, 8'h04);
        rd(3'h1, {6'h0, a[9:8]});
        wr(3'h4, 8'h00);
        rd(3'h4, 8'h00);
    endtask

    initial
    begin
        int n0;
        void'($urandom(13));
        for (int i = 0; i < 1024; i++)
        begin
            mem[i] = 8'($urandom);
            model[i] = mem[i];
        end
        repeat (8) @(posedge clk_i);
        rst_n_i <= 1'b1;
        por_n_i <= 1'b1;
        @(posedge clk_i);
        rd(3'h4, 8'h00);
        rd(3'h3, 8'h00);
        rd(3'h5, 8'h00);
        $display("test power-up reads done");
        // First row runs inside the hold; the rest break the launch rules
        for (int c = 0; c < 6; c++)
        begin
            n0 = we_cnt;
            wr(3'h4, PRE[c]);
            wr(3'h3, KA[c]);
            if (c == 5)
                wr(3'h0, 8'h00);
            wr(3'h3, KB[c]);
            wr(3'h4, LV[c]);
            idle(WC + 3);
            chk(16'(we_cnt), 16'(n0));
            rd(3'h4, EX[c]);
        end
        $display("test refused launches done");
        n0 = 8'($urandom);
        ext(1'b0, 1'b1, 10'h2A5, n0[7:0]);
        ext(1'b1, 1'b1, 10'h2A5, ~n0[7:0]);
        ext(1'b1, 1'b0, 10'h2A5, 8'h00);
        ext(1'b0, 1'b0, 10'h2A5, 8'h00);
        ext(1'b1, 1'b0, 10'h000, 8'h00);
        $display("test external access done");
        for (int i = 0; i < 4; i++)
            put((i == 0) ? 10'h3FF : 10'($urandom), 8'($urandom), 1'b0);
        $display("test byte writes done");
        put(10'h155, 8'h3C, 1'b1);
        $display("test reset during write done");
        close_out();
    end
endmodule

bind dewc_top dewc_chk #(.HOLD_CYCLES(HOLD_CYCLES)) dewc_chk_i (.clk_i(clk_i),
    .rst_n_i(rst_n_i), .por_n_i(por_n_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i),
    .sfr_sel_i(sfr_sel_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o),
    .nv_done_flag_o(nv_done_flag_o), .code_protect_i(code_protect_i),
    .ext_req_i(ext_req_i), .ext_denied_o(ext_denied_o), .arr_we_o(arr_we_o));
